// ---- rtl/ptr_pkg.sv ----
// Purpose: Shared constants and types for the program memory table reader.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   Register selects are local indices on the special function port.
package ptr_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int PTR_W      = 22;
    localparam int PROG_W     = 21;
    localparam int CFG_BIT    = 21;
    localparam int WORD_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // Register selects and field positions
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_PTR_LOW   = 2'h0;
    localparam logic [1:0] SEL_PTR_HIGH  = 2'h1;
    localparam logic [1:0] SEL_PTR_UPPER = 2'h2;
    localparam logic [1:0] SEL_LATCH     = 2'h3;
    localparam int         UPPER_USED    = 6;
    localparam int         LOW_LSB       = 0;
    localparam int         HIGH_LSB      = 8;
    localparam int         UPPER_LSB     = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [PTR_W-1:0]  PTR_RST   = 22'h000000;
    localparam logic [BYTE_W-1:0] LATCH_RST = 8'h00;

    // ------------------------------------------------------------------
    // Operations and states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ_HOLD_POINTER   = 3'h0,
        OP_READ_THEN_INCREMENT = 3'h1,
        OP_READ_THEN_DECREMENT = 3'h2,
        OP_INCREMENT_THEN_READ = 3'h3,
        OP_TABLE_WRITE         = 3'h4
    } ptr_op_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_ISSUE   = 4'h2,
        ST_CAPTURE = 4'h4,
        ST_WRITE   = 4'h8
    } ptr_state_t;

endpackage

// ---- rtl/ptr_fifo_if.sv ----
// Purpose: Carrier between the reader core and its byte FIFO.
// Assumes: Both ends on the core clock.
// Notes:   count is the registered occupancy.
`timescale 1ns/1ps
interface ptr_fifo_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
);
    logic                       push_valid;
    logic                       push_ready;
    logic [WIDTH-1:0]           push_data;
    logic                       pop_valid;
    logic                       pop_ready;
    logic [WIDTH-1:0]           pop_data;
    logic [$clog2(DEPTH+1)-1:0] count;

    modport fifo (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, count);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data, count);
endinterface

// ---- rtl/ptr_fifo.sv ----
// Purpose: Byte FIFO between the program memory read path and the latch.
// Assumes: Push and pop on the same clock.
// Notes:   Flags and count are registered; a pop frees room one edge later.
`timescale 1ns/1ps
module ptr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic i_ref_clk,
    input  wire logic i_sys_rst,
    ptr_fifo_if.fifo  port
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        full;
        logic                        empty;
    } ptr_fifo_state_t;

    ptr_fifo_state_t s_q;
    ptr_fifo_state_t s_d;
    logic            push;
    logic            pop;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign push            = port.push_valid && !s_q.full;
    assign pop             = port.pop_ready && !s_q.empty;
    assign port.push_ready = !s_q.full;
    assign port.pop_valid  = !s_q.empty;
    assign port.pop_data   = s_q.mem[s_q.rd_ptr];
    assign port.count      = s_q.count;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr_ptr] = port.push_data;
            s_d.wr_ptr          = wrap_inc(s_q.wr_ptr);
        end
        if (pop)
        begin
            s_d.rd_ptr = wrap_inc(s_q.rd_ptr);
        end
        if (push && !pop)
        begin
            s_d.count = CW'(s_q.count + 1'b1);
        end
        else if (pop && !push)
        begin
            s_d.count = CW'(s_q.count - 1'b1);
        end
        s_d.full  = (s_d.count == CW'(DEPTH));
        s_d.empty = (s_d.count == '0);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            s_q       <= '0;
            s_q.empty <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule // ptr_fifo

// ---- rtl/ptr_table_reader.sv ----
// Purpose: Byte-wide table read path from 16-bit program memory to data space.
// Assumes: Program memory returns a word one cycle after o_mem_rd.
// Notes:   Fetched bytes queue in a FIFO and drain into the read latch.
`timescale 1ns/1ps

// Contract
// RQ1: Every table read moves exactly one byte.
// RQ2: One byte of a 16-bit program word is chosen per read.
// RQ3: Any byte address may start or end a table block.
// RQ4: Program memory is never written or erased in normal operation.
// RQ5: Table write outside programming mode takes two cycles and changes nothing.
// RQ6: Table write acts only in programming mode.
// RQ7: Pointer is 22 bits: upper low six bits, high byte, low byte.
// RQ8: Low 21 bits address program space; bit 21 selects configuration space.
// RQ9: Automatic increment and decrement change only the low 21 bits.
// RQ10: All 22 pointer bits select the byte loaded into the latch.
// RQ11: Four read forms: hold, post-increment, post-decrement, pre-increment.
// RQ12: Pointer bit 0 chooses high or low byte of the word.
// RQ13: Even address returns the low byte, odd the high byte.
// RQ14: Read latch is an 8-bit readable register holding the fetched byte.
// RQ15: Upper byte: bit 5 is configuration select, bits 4..0 pointer 20..16.
// RQ16: High byte holds pointer 15..8, low byte pointer 7..0.
// RQ17: Unimplemented pointer bits read as zero.
module ptr_table_reader
    import ptr_pkg::*;
#(
    parameter int DEPTH = ptr_pkg::FIFO_DEPTH
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_sys_rst,
    // Operation port from the core
    input  wire logic                       i_op_valid,
    input  wire ptr_pkg::ptr_op_t           i_op_kind,
    output logic                            o_op_ready,
    // Control register port
    input  wire logic                       i_csr_wr,
    input  wire logic                       i_csr_rd,
    input  wire logic [1:0]                 i_csr_sel,
    input  wire logic [ptr_pkg::BYTE_W-1:0] i_csr_wdata,
    output logic [ptr_pkg::BYTE_W-1:0]      o_csr_rdata,
    // Latch hand-off to data space
    output logic [ptr_pkg::BYTE_W-1:0]      o_latch,
    output logic                            o_latch_valid,
    input  wire logic                       i_latch_take,
    // Programming mode strap (asynchronous)
    input  wire logic                       i_prog_mode,
    // Program memory
    output logic                            o_mem_rd,
    output logic [ptr_pkg::PTR_W-2:0]       o_mem_word_addr,
    input  wire logic [ptr_pkg::WORD_W-1:0] i_mem_rdata,
    output logic                            o_mem_wr,
    output logic [ptr_pkg::PTR_W-1:0]       o_mem_waddr,
    output logic [ptr_pkg::BYTE_W-1:0]      o_mem_wdata
);
    import ptr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ptr_state_t          state;
        logic [PTR_W-1:0]    ptr;
        logic [BYTE_W-1:0]   latch;
        logic                latch_valid;
        logic                byte_hi;
        logic                op_ready;
        logic                mem_rd;
        logic [PTR_W-2:0]    mem_word_addr;
        logic                mem_wr;
        logic [PTR_W-1:0]    mem_waddr;
        logic [BYTE_W-1:0]   mem_wdata;
        logic [BYTE_W-1:0]   csr_rdata;
        logic                prog_s1;
        logic                prog_s2;
    } ptr_reader_state_t;

    localparam int CW = $clog2(DEPTH+1);

    ptr_reader_state_t s_q;
    ptr_reader_state_t s_d;
    logic              accept;
    logic [PTR_W-1:0]  read_addr;

    ptr_fifo_if #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) fifo_bus ();

    ptr_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .port      (fifo_bus.fifo)
    );

    // ------------------------------------------------------------------
    // Pointer arithmetic
    // ------------------------------------------------------------------
    // Carry and borrow stay inside the program field so that a walk past
    // either end never flips into configuration space.
    function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p,
                                                  input logic              down);
        logic [PROG_W-1:0] low;
        low = down ? PROG_W'(p[PROG_W-1:0] - 1'b1) : PROG_W'(p[PROG_W-1:0] + 1'b1); // RQ9
        step_ptr = {p[CFG_BIT], low}; // RQ9
    endfunction

    function automatic logic [BYTE_W-1:0] read_reg(input logic [1:0]        sel,
                                                   input logic [PTR_W-1:0]  p,
                                                   input logic [BYTE_W-1:0] lat);
        unique case (sel)
            SEL_PTR_LOW:   read_reg = p[HIGH_LSB-1:LOW_LSB]; // RQ16
            SEL_PTR_HIGH:  read_reg = p[UPPER_LSB-1:HIGH_LSB]; // RQ16
            SEL_PTR_UPPER: read_reg = {2'h0, p[PTR_W-1:UPPER_LSB]}; // RQ15 RQ17
            SEL_LATCH:     read_reg = lat; // RQ14
        endcase
    endfunction

    // The form with pre-increment reads from the already stepped address.
    assign read_addr = (i_op_kind == OP_INCREMENT_THEN_READ) ? step_ptr(s_q.ptr, 1'b0) : s_q.ptr; // RQ11

    assign accept = s_q.op_ready && i_op_valid;

    // ------------------------------------------------------------------
    // FIFO hook-up
    // ------------------------------------------------------------------
    // One byte of the returned word is queued per read.
    assign fifo_bus.push_valid = (s_q.state == ST_CAPTURE); // RQ1
    assign fifo_bus.push_data  = s_q.byte_hi ? i_mem_rdata[WORD_W-1:BYTE_W]
                                             : i_mem_rdata[BYTE_W-1:0]; // RQ2 RQ12 RQ13
    // Latch drain stalls while the core has not taken the previous byte.
    assign fifo_bus.pop_ready  = !s_q.latch_valid || i_latch_take;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d         = s_q;
        s_d.mem_rd  = 1'b0;
        s_d.mem_wr  = 1'b0;
        s_d.prog_s1 = i_prog_mode;
        s_d.prog_s2 = s_q.prog_s1;

        // Register writes; a pointer step in the same cycle takes priority
        if (i_csr_wr)
        begin
            unique case (i_csr_sel)
                SEL_PTR_LOW:   s_d.ptr[HIGH_LSB-1:LOW_LSB]   = i_csr_wdata; // RQ16
                SEL_PTR_HIGH:  s_d.ptr[UPPER_LSB-1:HIGH_LSB] = i_csr_wdata; // RQ16
                SEL_PTR_UPPER: s_d.ptr[PTR_W-1:UPPER_LSB]    = i_csr_wdata[UPPER_USED-1:0]; // RQ7 RQ15
                SEL_LATCH:     s_d.latch                     = i_csr_wdata; // RQ14
            endcase
        end

        unique case (s_q.state)
            ST_IDLE:
            begin
                if (accept)
                begin
                    if (i_op_kind == OP_TABLE_WRITE)
                    begin
                        s_d.state = ST_WRITE; // RQ5
                    end
                    else
                    begin
                        // Full 22-bit address: bit 21 picks configuration space
                        s_d.mem_rd        = 1'b1; // RQ4
                        s_d.mem_word_addr = read_addr[PTR_W-1:1]; // RQ8 RQ10
                        s_d.byte_hi       = read_addr[0]; // RQ3 RQ12
                        s_d.state         = ST_ISSUE;
                        unique case (i_op_kind)
                            OP_READ_THEN_INCREMENT: s_d.ptr = step_ptr(s_q.ptr, 1'b0); // RQ11
                            OP_READ_THEN_DECREMENT: s_d.ptr = step_ptr(s_q.ptr, 1'b1); // RQ11
                            OP_INCREMENT_THEN_READ: s_d.ptr = read_addr; // RQ11
                            default:                s_d.ptr = s_d.ptr; // RQ11
                        endcase
                    end
                end
            end
            ST_ISSUE:
            begin
                s_d.state = ST_CAPTURE;
            end
            ST_CAPTURE:
            begin
                s_d.state = ST_IDLE;
            end
            ST_WRITE:
            begin
                // Second cycle of the write; memory sees it only when programming
                if (s_q.prog_s2)
                begin
                    s_d.mem_wr    = 1'b1; // RQ6
                    s_d.mem_waddr = s_q.ptr; // RQ6
                    s_d.mem_wdata = s_q.latch; // RQ6
                end
                s_d.state = ST_IDLE; // RQ5
            end
        endcase

        // Latch update from the queue, after any register write to it
        if (i_latch_take)
        begin
            s_d.latch_valid = 1'b0;
        end
        if (fifo_bus.pop_valid && fifo_bus.pop_ready)
        begin
            s_d.latch       = fifo_bus.pop_data; // RQ10 RQ14
            s_d.latch_valid = 1'b1;
        end

        // Conservative room check: a byte may still land from the capture
        // now under way, so a read needs two free slots and the FIFO can still fill.
        s_d.op_ready = (s_d.state == ST_IDLE) && (fifo_bus.count <= CW'(DEPTH-2));

        if (i_csr_rd)
        begin
            s_d.csr_rdata = read_reg(i_csr_sel, s_q.ptr, s_q.latch); // RQ17
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            s_q       <= '0;
            s_q.state <= ST_IDLE;
            s_q.ptr   <= PTR_RST;
            s_q.latch <= LATCH_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_op_ready      = s_q.op_ready;
    assign o_csr_rdata     = s_q.csr_rdata;
    assign o_latch         = s_q.latch;
    assign o_latch_valid   = s_q.latch_valid;
    assign o_mem_rd        = s_q.mem_rd;
    assign o_mem_word_addr = s_q.mem_word_addr;
    assign o_mem_wr        = s_q.mem_wr;
    assign o_mem_waddr     = s_q.mem_waddr;
    assign o_mem_wdata     = s_q.mem_wdata;

endmodule // ptr_table_reader

// ---- sim/ptr_mem_model.sv ----
// Purpose: Program memory model that answers the reader's word fetches.
// Assumes: One-cycle read latency, as the reader expects.
// Notes:   Data is a pattern of the word address; outside the answer cycle it toggles.
`timescale 1ns/1ps
module ptr_mem_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rd,
    input  wire logic [20:0] i_addr,
    output logic      [15:0] o_rdata
);
    // Stale data is inverted every cycle so a capture one cycle late never looks right
    initial o_rdata = 16'hA5A5;
    always @(posedge i_ref_clk)
    begin
        if (i_rd)
            o_rdata <= {i_addr[7:0] ^ i_addr[20:13], ~i_addr[7:0]};
        else
            o_rdata <= ~o_rdata;
    end
    // Write port is not modelled: the data is only a pattern of the address
endmodule // ptr_mem_model

// ---- sim/ptr_table_reader_sva.sv ----
// Purpose: Port-level checks for the table reader.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Sees top-level ports only.
`timescale 1ns/1ps
module ptr_table_reader_sva
    import ptr_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic                       i_ref_clk,
    input wire logic                       i_sys_rst,
    input wire logic                       i_op_valid,
    input wire ptr_pkg::ptr_op_t           i_op_kind,
    input wire logic                       o_op_ready,
    input wire logic                       i_csr_rd,
    input wire logic [1:0]                 i_csr_sel,
    input wire logic [ptr_pkg::BYTE_W-1:0] o_csr_rdata,
    input wire logic [ptr_pkg::BYTE_W-1:0] o_latch,
    input wire logic                       o_latch_valid,
    input wire logic                       i_prog_mode,
    input wire logic                       o_mem_rd,
    input wire logic                       o_mem_wr,
    input wire logic [ptr_pkg::BYTE_W-1:0] o_mem_wdata
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic take;
    logic rd_take;
    assign take    = i_op_valid && o_op_ready;
    assign rd_take = take && (i_op_kind != OP_TABLE_WRITE);
    a_read_fetches: assert property (rd_take |-> ##[1:2] o_mem_rd)
        else $error("read taken without a fetch");
    a_fetch_single: assert property (o_mem_rd |=> !o_mem_rd)
        else $error("fetch strobe longer than one cycle");
    a_read_busy_span: assert property (rd_take |=> !o_op_ready [*2])
        else $error("read accepted again too soon");
    a_ready_drops: assert property (take |=> !o_op_ready)
        else $error("ready stayed high after take");
    a_write_no_fetch: assert property (take && i_op_kind == OP_TABLE_WRITE |-> ##1 !o_mem_rd ##1 !o_mem_rd)
        else $error("table write fetched memory");
    // Seven quiet samples cover the two-flop synchroniser and the write latency
    a_write_needs_prog: assert property ((!i_prog_mode) [*7] |-> !o_mem_wr)
        else $error("memory write outside programming mode");
    a_write_data_latch: assert property (o_mem_wr |-> o_mem_wdata == o_latch)
        else $error("write data differs from latch");
    a_fetch_fills_latch: assert property (o_mem_rd |-> ##[1:4] o_latch_valid)
        else $error("fetched byte never reached latch");
    a_upper_top_zero: assert property (i_csr_rd && i_csr_sel == SEL_PTR_UPPER |=> o_csr_rdata[7:6] == 2'h0)
        else $error("unimplemented upper bits read nonzero");
    a_rdata_holds: assert property (!i_csr_rd |=> $stable(o_csr_rdata))
        else $error("register read data changed without a read");
    c_read_taken: cover property (rd_take);
    c_mem_write: cover property (o_mem_wr);
    c_upper_read: cover property (i_csr_rd && i_csr_sel == SEL_PTR_UPPER);
endmodule // ptr_table_reader_sva

// ---- sim/ptr_table_reader_tb.sv ----
// Purpose: Self-checking bench for the table reader.
// Assumes: Memory model answers one cycle after each fetch.
// Notes:   Inputs change by non-blocking assignment at the rising edge.
`timescale 1ns/1ps
module ptr_table_reader_tb;
    import ptr_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, op_ready;
    ptr_op_t op_kind = OP_READ_HOLD_POINTER;
    logic csr_wr = 1'b0, csr_rd = 1'b0, latch_take = 1'b0, prog_mode = 1'b0;
    logic [1:0] csr_sel = 2'h0;
    logic [7:0] csr_wdata = 8'h00, csr_rdata, latch, mem_wdata;
    logic latch_valid, mem_rd, mem_wr;
    logic [20:0] mem_addr;
    logic [15:0] mem_rdata;
    logic [21:0] mem_waddr;
    int num_errors = 0, checks = 0, cyc = 0;
    always #5 ref_clk = ~ref_clk;
    ptr_table_reader #(.DEPTH(8)) u_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_op_valid(op_valid),
        .i_op_kind(op_kind), .o_op_ready(op_ready), .i_csr_wr(csr_wr), .i_csr_rd(csr_rd), .i_csr_sel(csr_sel),
        .i_csr_wdata(csr_wdata), .o_csr_rdata(csr_rdata), .o_latch(latch), .o_latch_valid(latch_valid),
        .i_latch_take(latch_take), .i_prog_mode(prog_mode), .o_mem_rd(mem_rd), .o_mem_word_addr(mem_addr),
        .i_mem_rdata(mem_rdata), .o_mem_wr(mem_wr), .o_mem_waddr(mem_waddr), .o_mem_wdata(mem_wdata));
    ptr_mem_model u_mem (.i_ref_clk(ref_clk), .i_rd(mem_rd), .i_addr(mem_addr), .o_rdata(mem_rdata));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic final_report();
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [21:0] p);
        logic [15:0] w;
        w = {p[8:1] ^ p[21:14], ~p[8:1]};
        return p[0] ? w[15:8] : w[7:0];
    endfunction
    task automatic reg_wr(input logic [1:0] s, input logic [7:0] d);
        csr_wr <= 1'b1;
        csr_sel <= s;
        csr_wdata <= d;
        @(posedge ref_clk);
        csr_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic reg_rd(input logic [1:0] s, output logic [7:0] d);
        csr_rd <= 1'b1;
        csr_sel <= s;
        @(posedge ref_clk);
        csr_rd <= 1'b0;
        @(posedge ref_clk);
        d = csr_rdata;
    endtask
    task automatic set_ptr(input logic [21:0] p);
        reg_wr(SEL_PTR_UPPER, {2'h0, p[21:16]});
        reg_wr(SEL_PTR_HIGH, p[15:8]);
        reg_wr(SEL_PTR_LOW, p[7:0]);
    endtask
    task automatic get_ptr(output logic [21:0] p);
        logic [7:0] u, h, l;
        reg_rd(SEL_PTR_UPPER, u);
        chk(24'h0, u[7:6]);
        reg_rd(SEL_PTR_HIGH, h);
        reg_rd(SEL_PTR_LOW, l);
        p = {u[5:0], h, l};
    endtask
    // Gives up after a bounded wait so a refused request can be observed
    task automatic do_op(input ptr_op_t k, output logic ok);
        int n;
        n = 0;
        op_kind <= k;
        op_valid <= 1'b1;
        @(posedge ref_clk);
        while (op_ready !== 1'b1 && n < 12)
        begin
            n++;
            @(posedge ref_clk);
        end
        ok = (op_ready === 1'b1);
        op_valid <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic take_byte(output logic [7:0] b);
        int n;
        n = 0;
        while (latch_valid !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge ref_clk);
        end
        b = latch;
        latch_take <= 1'b1;
        @(posedge ref_clk);
        latch_take <= 1'b0;
        @(posedge ref_clk);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_and_fields();
        logic [7:0] d;
        logic [21:0] p;
        for (int s = 0; s < 4; s++)
        begin
            reg_rd(s[1:0], d);
            chk(24'h0, d);
        end
        reg_wr(SEL_PTR_UPPER, 8'hFF);
        reg_rd(SEL_PTR_UPPER, d);
        chk(24'h3F, d);
        reg_wr(SEL_PTR_HIGH, 8'hA6);
        reg_wr(SEL_PTR_LOW, 8'h5B);
        get_ptr(p);
        chk(24'h3FA65B, p);
    endtask
    // Starts at the top of configuration space so steps must wrap in 21 bits
    task automatic t_read_modes();
        ptr_op_t ops[4];
        logic [21:0] p, a, q;
        logic [7:0] b;
        logic ok;
        ops = '{OP_READ_THEN_INCREMENT, OP_READ_THEN_DECREMENT, OP_INCREMENT_THEN_READ, OP_READ_HOLD_POINTER};
        p = 22'h3FFFFF;
        set_ptr(p);
        foreach (ops[i])
        begin
            if (ops[i] == OP_INCREMENT_THEN_READ)
                p = {p[21], p[20:0] + 21'h1};
            a = p;
            if (ops[i] == OP_READ_THEN_INCREMENT)
                p = {p[21], p[20:0] + 21'h1};
            if (ops[i] == OP_READ_THEN_DECREMENT)
                p = {p[21], p[20:0] - 21'h1};
            do_op(ops[i], ok);
            take_byte(b);
            chk(exp_byte(a), b);
            get_ptr(q);
            chk(p, q);
        end
    endtask
    task automatic t_table_write();
        logic [21:0] p, q, wa;
        logic [7:0] wd;
        logic ok, seen;
        get_ptr(p);
        do_op(OP_TABLE_WRITE, ok);
        chk(24'h1, ok);
        seen = 1'b0;
        repeat (6)
        begin
            @(posedge ref_clk);
            seen = seen | (mem_wr === 1'b1);
        end
        chk(24'h0, seen);
        get_ptr(q);
        chk(p, q);
        reg_wr(SEL_LATCH, 8'hC3);
        reg_rd(SEL_LATCH, wd);
        chk(24'hC3, wd);
        prog_mode <= 1'b1;
        repeat (4) @(posedge ref_clk);
        do_op(OP_TABLE_WRITE, ok);
        repeat (8)
        begin
            @(posedge ref_clk);
            if (mem_wr === 1'b1 && !seen)
            begin
                seen = 1'b1;
                wa = mem_waddr;
                wd = mem_wdata;
            end
        end
        chk(24'h1, seen);
        chk(p, wa);
        chk(24'hC3, wd);
        prog_mode <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    // Latch never taken: the buffer must fill and refuse, then drain intact
    task automatic t_buffer_fill();
        int acc;
        logic ok;
        logic [7:0] b;
        acc = 0;
        set_ptr(22'h012345);
        repeat (12)
        begin
            do_op(OP_READ_HOLD_POINTER, ok);
            acc += ok;
        end
        chk(24'(FIFO_DEPTH + 1), acc);
        repeat (acc)
        begin
            take_byte(b);
            chk(exp_byte(22'h012345), b);
        end
        repeat (5) @(posedge ref_clk);
        chk(24'h0, latch_valid);
    endtask
    // ------------------------------------------------------------------
    // Sequence and timeout
    // ------------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            final_report();
        end
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset_and_fields();
        t_read_modes();
        t_table_write();
        t_buffer_fill();
        final_report();
    end
endmodule // ptr_table_reader_tb
bind ptr_table_reader ptr_table_reader_sva #(.DEPTH(DEPTH)) u_sva (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_op_valid(i_op_valid), .i_op_kind(i_op_kind), .o_op_ready(o_op_ready), .i_csr_rd(i_csr_rd),
    .i_csr_sel(i_csr_sel), .o_csr_rdata(o_csr_rdata), .o_latch(o_latch), .o_latch_valid(o_latch_valid),
    .i_prog_mode(i_prog_mode), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata));
